/* design/rsa_pkg.sv */
// shared constants and types of the rate sensor converter command port
package rsa_pkg;
    // ======================================================
    // widths
    localparam int RES_W = 11; // converter result bits
    localparam int ANS_W = 16; // answer word bits
    localparam int INS_W = 8; // instruction byte bits
    localparam int CNT_W = 5; // serial clock edge counter

    // ======================================================
    // instruction codes
    localparam logic [7:0] CMD_STATUS = 8'h88; // status_read_cmd
    localparam logic [7:0] CMD_RESULT = 8'h80; // result_read_cmd
    localparam logic [3:0] CMD_CTL_HI = 4'h9; // converter_control_cmd
    localparam logic [1:0] CMD_CTL_LO = 2'h0; // low bits of control
    localparam int INS_SEL_BIT = 3; // channel select in instruction
    localparam int INS_PWR_BIT = 2; // power enable in instruction

    // ======================================================
    // answer bit positions
    localparam int ANS_REFUSE_BIT = 15;
    localparam int ANS_UNK_BIT = 14;
    localparam int ANS_DONE_BIT = 13;
    localparam int ANS_BUSY_BIT = 10;
    localparam int ANS_SEL_BIT = 3;
    localparam int ANS_PWR_BIT = 2;
    localparam int ANS_RES_LSB = 1;

    // ======================================================
    // frame positions in serial clock edges
    localparam logic [4:0] INS_LAST_EDGE = 5'h07; // count at 8th edge
    localparam logic [4:0] ANS_FIRST = 5'h08; // first answer slot
    localparam logic [4:0] FRAME_END = 5'h18; // 24 edges, frame done
    localparam logic [4:0] ANS_TOP = 5'h17; // maps slot to bit index

    // ======================================================
    // reset values
    localparam logic RST_SEL = 1'h0; // rate input selected
    localparam logic RST_PWR = 1'h0; // converter asleep
    localparam logic RST_DONE = 1'h1; // conversion may start
    localparam logic RST_BUSY = 1'h1; // initialising

    // ======================================================
    // timing on the 40 MHz main clock
    localparam int MCLK_MHZ = 40;
    localparam int TRACK_NS = 2000; // least acquisition time
    localparam int BIT_NS = 8000; // least time per result bit
    localparam int TRACK_CYC = (TRACK_NS * MCLK_MHZ + 999) / 1000;
    localparam int BIT_CYC = (BIT_NS * MCLK_MHZ + 999) / 1000;
    localparam int INIT_CYC = 1024; // internal initialisation length
    localparam int INIT_W = 20; // init counter width

    // ======================================================
    // types
    typedef struct packed {
        logic input_channel_select;
        logic converter_power_enable;
    } rsa_ctl_s;

    typedef struct packed {
        logic busy;
        logic done;
        logic input_channel_select;
        logic converter_power_enable;
    } rsa_stat_s;

    typedef enum logic [1:0] {
        SAR_IDLE = 2'h0,
        SAR_TRACK = 2'h1,
        SAR_STEP = 2'h2,
        SAR_DONE = 2'h3
    } rsa_sar_e;
endpackage

/* design/rsa_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/100ps
module rsa_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg; // first stage, read only by sync_o

    // ======================================================
    // two stages
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_reg <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_reg <= async_i;
            sync_o <= meta_reg;
        end
    end
endmodule

/* design/rsa_sar.sv */
// successive approximation sequencer with input select and power
`timescale 1ns/100ps
module rsa_sar import rsa_pkg::*; #(
    parameter int TRACK_CYCLES = TRACK_CYC,
    parameter int BIT_CYCLES = BIT_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic ctl_evt_i,
    input wire rsa_ctl_s ctl_i,
    input wire logic cmp_above_i,
    output rsa_ctl_s mode_o,
    output logic done_o,
    output logic hold_o,
    output logic [RES_W-1:0] dac_code_o,
    output logic [RES_W-1:0] result_o
);
    localparam logic [15:0] TRACK_LD = 16'(TRACK_CYCLES - 1);
    localparam logic [15:0] BIT_LD = 16'(BIT_CYCLES - 1);
    localparam logic [RES_W-1:0] MSB_ONE = {1'b1, {(RES_W-1){1'b0}}};

    rsa_sar_e state_reg; // sequencer state
    logic [15:0] wait_reg; // settling countdown
    logic [RES_W-1:0] trial_reg; // one-hot bit under trial

    // decode of requests and bit decisions
    wire start = ctl_evt_i & ctl_i.converter_power_enable & done_o;
    wire sleep = ctl_evt_i & ~ctl_i.converter_power_enable;
    wire wait_over = (wait_reg == 16'h0000);
    wire [RES_W-1:0] kept = cmp_above_i ? dac_code_o
                                        : (dac_code_o & ~trial_reg);

    // ======================================================
    // sequencer
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= SAR_IDLE;
            mode_o <= '{RST_SEL, RST_PWR};
            done_o <= RST_DONE;
            hold_o <= 1'b0;
            wait_reg <= '0;
            trial_reg <= '0;
            dac_code_o <= '0;
            result_o <= '0;
        end else begin
            if (ctl_evt_i) begin
                mode_o <= ctl_i; // latch both flags
            end
            if (sleep) begin
                state_reg <= SAR_IDLE; // sleep aborts
                done_o <= 1'b1;
                hold_o <= 1'b0;
            end else begin
                unique case (state_reg)
                    SAR_IDLE: begin
                        if (start) begin
                            state_reg <= SAR_TRACK;
                            done_o <= 1'b0;
                            wait_reg <= TRACK_LD;
                        end
                    end
                    SAR_TRACK: begin
                        if (wait_over) begin // freeze input
                            state_reg <= SAR_STEP;
                            hold_o <= 1'b1;
                            trial_reg <= MSB_ONE;
                            dac_code_o <= MSB_ONE;
                            wait_reg <= BIT_LD;
                        end else begin
                            wait_reg <= wait_reg - 16'h0001;
                        end
                    end
                    SAR_STEP: begin
                        if (!wait_over) begin
                            wait_reg <= wait_reg - 16'h0001;
                        end else if (trial_reg[0]) begin
                            result_o <= kept;
                            state_reg <= SAR_DONE;
                        end else begin
                            trial_reg <= trial_reg >> 1;
                            dac_code_o <= kept | (trial_reg >> 1);
                            wait_reg <= BIT_LD;
                        end
                    end
                    SAR_DONE: begin
                        // flag rises a cycle after the result settles
                        done_o <= 1'b1;
                        hold_o <= 1'b0;
                        state_reg <= SAR_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

/* design/rsa_cmd_port.sv */
// serial command port controlling and reading the embedded converter
`timescale 1ns/100ps
module rsa_cmd_port import rsa_pkg::*; #(
    parameter int INIT_CYCLES = INIT_CYC,
    parameter int TRACK_CYCLES = TRACK_CYC,
    parameter int BIT_CYCLES = BIT_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic sclk_i,
    input wire logic ss_b_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    input wire logic cmp_above_i,
    output logic [RES_W-1:0] dac_code_o,
    output logic sample_hold_o,
    output logic mux_select_o,
    output logic conv_power_o
);
    // ======================================================
    // main clock domain signals

    logic [INIT_W-1:0] init_cnt_reg; // initialisation timer
    logic busy_reg; // initialisation in progress
    logic tog_sync; // control toggle after two stages
    logic tog_seen_reg; // last toggle value acted on
    logic cmp_sync; // comparator after two stages
    rsa_ctl_s mode; // latched select and power flags
    logic done; // conversion complete flag
    logic [RES_W-1:0] result; // last conversion result

    // ======================================================
    // serial clock domain signals

    logic [CNT_W-1:0] bit_cnt_reg; // rising edges in this frame
    logic [INS_W-1:0] shift_reg; // instruction shift register
    logic [ANS_W-1:0] answer_reg; // answer prepared at 8th edge
    logic tog_reg; // flips once per accepted control
    rsa_ctl_s ctl_data_reg; // flags held for the main domain
    logic unk_flag_reg; // unknown instruction seen
    rsa_stat_s stat_sync; // status seen from serial side
    logic [RES_W-1:0] result_sync; // result seen from serial side

    // ======================================================
    // frame reset: deselect returns the frame logic to start state

    // deselect clears the frame logic at once
    wire spi_rst_b = rst_b_i & ~ss_b_i;

    // ======================================================
    // initialisation timer

    // busy holds from reset until the timer expires
    wire init_last = (init_cnt_reg == INIT_W'(INIT_CYCLES - 1));

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            init_cnt_reg <= '0;
            busy_reg <= RST_BUSY;
        end else if (busy_reg) begin
            init_cnt_reg <= init_cnt_reg + INIT_W'(1);
            busy_reg <= ~init_last;
        end
    end

    // ======================================================
    // control event crossing into the main domain

    // toggle from the serial side passes two stages first
    rsa_sync #(
        .WIDTH(1),
        .RST_VAL(1'b0)
    ) u_tog_sync (
        .clk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .async_i(tog_reg),
        .sync_o(tog_sync)
    );

    // a change of the synced toggle is one control event
    wire ctl_evt = tog_sync ^ tog_seen_reg;

    // remember which toggle value was acted on
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tog_seen_reg <= 1'b0;
        end else begin
            tog_seen_reg <= tog_sync;
        end
    end

    // ======================================================
    // comparator input from the analog side

    // the comparator is not timed to mclk, so it is synchronised
    rsa_sync #(
        .WIDTH(1),
        .RST_VAL(1'b0)
    ) u_cmp_sync (
        .clk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .async_i(cmp_above_i),
        .sync_o(cmp_sync)
    );

    // ======================================================
    // converter sequencer

    // ctl_data_reg stays still from toggle until long after the
    // event, so reading it here at the event is safe
    rsa_sar #(
        .TRACK_CYCLES(TRACK_CYCLES),
        .BIT_CYCLES(BIT_CYCLES)
    ) u_sar (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .ctl_evt_i(ctl_evt),
        .ctl_i(ctl_data_reg),
        .cmp_above_i(cmp_sync),
        .mode_o(mode),
        .done_o(done),
        .hold_o(sample_hold_o),
        .dac_code_o(dac_code_o),
        .result_o(result)
    );

    // sequencer flops drive the analog controls directly
    // mux: zero picks the rate node, one the temperature node
    assign mux_select_o = mode.input_channel_select;
    // power enable low keeps the converter asleep
    assign conv_power_o = mode.converter_power_enable;

    // ======================================================
    // status crossing into the serial domain

    // the serial clock stops between frames; the eight instruction
    // edges give the two stages time to refresh before use
    rsa_sync #(
        .WIDTH($bits(rsa_stat_s)),
        .RST_VAL({RST_BUSY, RST_DONE, RST_SEL, RST_PWR})
    ) u_stat_sync (
        .clk_i(sclk_i),
        .rst_b_i(rst_b_i),
        .async_i({busy_reg, done, mode}),
        .sync_o(stat_sync)
    );

    // result is only rewritten while done is low, a cycle before
    // done rises, so a sample taken with done high is coherent
    rsa_sync #(
        .WIDTH(RES_W),
        .RST_VAL('0)
    ) u_res_sync (
        .clk_i(sclk_i),
        .rst_b_i(rst_b_i),
        .async_i(result),
        .sync_o(result_sync)
    );

    // ======================================================
    // instruction decode

    // instruction as complete on the 8th rising edge
    wire [INS_W-1:0] instr = {shift_reg[INS_W-2:0], mosi_i};
    wire exec = (bit_cnt_reg == INS_LAST_EDGE);
    wire is_status = (instr == CMD_STATUS);
    wire is_result = (instr == CMD_RESULT);
    // control: fixed high nibble and zero low bits
    wire is_ctl = (instr[7:4] == CMD_CTL_HI)
                  & (instr[1:0] == CMD_CTL_LO);
    wire known = is_status | is_result | is_ctl;
    wire ctl_pwr = instr[INS_PWR_BIT];
    wire ctl_sel = instr[INS_SEL_BIT];
    // a start while converting is refused
    wire start_clash = is_ctl & ctl_pwr & ~stat_sync.done;
    // refusal while busy, unknown or clashing
    wire refuse = stat_sync.busy | ~known | start_clash;
    // unknown instruction sets the flag, accepted one clears it
    wire unk_next = ~known | (unk_flag_reg & refuse);
    // an accepted control starting a conversion shows done low
    wire done_shown = stat_sync.done & ~(is_ctl & ctl_pwr);
    // flags shown in status style answers
    wire sel_shown = is_ctl ? ctl_sel : stat_sync.input_channel_select;
    wire pwr_shown = is_ctl ? ctl_pwr
                            : stat_sync.converter_power_enable;

    // ======================================================
    // answer words; undefined bits are zero

    // refusal: bit 15 high is unique to it
    wire [ANS_W-1:0] ans_refuse =
        (ANS_W'(1) << ANS_REFUSE_BIT)
        | (ANS_W'(unk_next) << ANS_UNK_BIT)
        | (ANS_W'(stat_sync.done) << ANS_DONE_BIT)
        | (ANS_W'(stat_sync.busy) << ANS_BUSY_BIT);

    // status and control answer share one layout
    wire [ANS_W-1:0] ans_status =
        (ANS_W'(done_shown) << ANS_DONE_BIT)
        | (ANS_W'(sel_shown) << ANS_SEL_BIT)
        | (ANS_W'(pwr_shown) << ANS_PWR_BIT);

    // result answer carries the result msb first
    wire [ANS_W-1:0] ans_result =
        (ANS_W'(stat_sync.done) << ANS_DONE_BIT)
        | (ANS_W'(result_sync) << ANS_RES_LSB);

    // every instruction gets exactly one of the three
    wire [ANS_W-1:0] ans_next = refuse ? ans_refuse
                              : (is_result ? ans_result : ans_status);

    // ======================================================
    // frame counter, shift register, answer capture

    // counting stops at the frame end until deselect
    wire frame_open = (bit_cnt_reg != FRAME_END);
    wire in_instr = (bit_cnt_reg < ANS_FIRST);

    always_ff @(posedge sclk_i or negedge spi_rst_b) begin
        if (!spi_rst_b) begin
            bit_cnt_reg <= '0;
            shift_reg <= '0;
            answer_reg <= '0;
        end else begin
            if (frame_open) begin
                bit_cnt_reg <= bit_cnt_reg + CNT_W'(1);
            end
            if (in_instr) begin
                shift_reg <= instr; // sample on rising edge
            end
            if (exec) begin
                answer_reg <= ans_next;
            end
        end
    end

    // ======================================================
    // effects that must outlive the frame

    // these flops ignore deselect so a finished command keeps its
    // effect; a frame cut before edge 8 never reaches exec
    always_ff @(posedge sclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tog_reg <= 1'b0;
            ctl_data_reg <= '{RST_SEL, RST_PWR};
            unk_flag_reg <= 1'b0;
        end else if (exec) begin
            unk_flag_reg <= unk_next;
            if (is_ctl && !refuse) begin
                // hand select and power over
                ctl_data_reg <= '{ctl_sel, ctl_pwr};
                tog_reg <= ~tog_reg;
            end
        end
    end

    // ======================================================
    // answer output on falling edges

    // slot 8 carries bit 15 down to slot 23 carrying bit 0
    wire in_answer = (bit_cnt_reg >= ANS_FIRST) & frame_open;
    wire [CNT_W-1:0] ans_slot = ANS_TOP - bit_cnt_reg;
    wire ans_bit = answer_reg[ans_slot[3:0]];

    // miso is released the moment the frame is deselected
    always_ff @(negedge sclk_i or negedge spi_rst_b) begin
        if (!spi_rst_b) begin
            miso_o <= 1'b0;
            miso_oe_o <= 1'b0;
        end else if (in_answer) begin
            miso_o <= ans_bit; // msb first
            miso_oe_o <= 1'b1;
        end else begin
            miso_o <= 1'b0; // nothing after the last answer bit
        end
    end
endmodule

/* tb/rsa_cmd_port_sva.sv */
// assertion checker for the converter command port
`timescale 1ns/100ps
module rsa_cmd_port_sva import rsa_pkg::*; (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic sclk_i,
    input wire logic ss_b_i,
    input wire logic mosi_i,
    input wire logic miso_o,
    input wire logic miso_oe_o,
    input wire logic sample_hold_o,
    input wire logic mux_select_o,
    input wire logic conv_power_o
);
    // ==========================================
    // frame tracking in the serial clock domain
    logic [4:0] rise_cnt_reg; // rises seen in this frame
    logic [7:0] ins_reg; // instruction bits gathered
    wire logic ins_known; // byte is one of the three codes
    assign ins_known = (ins_reg == CMD_STATUS) || (ins_reg == CMD_RESULT)
        || (ins_reg[7:4] == CMD_CTL_HI && ins_reg[1:0] == CMD_CTL_LO);
    // deselect clears the tracker, as it does the port
    always_ff @(posedge sclk_i or posedge ss_b_i) begin
        if (ss_b_i) begin
            rise_cnt_reg <= 5'h00;
            ins_reg <= 8'h00;
        end else begin
            if (rise_cnt_reg != 5'h1f) rise_cnt_reg <= rise_cnt_reg + 5'h01;
            if (rise_cnt_reg < 5'h08) ins_reg <= {ins_reg[6:0], mosi_i};
        end
    end
    // refusal head: bit 15 set, bits 12 and 11 zero
    sequence s_refusal_head;
        miso_o ##3 !miso_o ##1 !miso_o;
    endsequence
    // ==========================================
    // serial side
    a_oe_window: assert property (@(posedge sclk_i) disable iff (ss_b_i || !rst_b_i)
        miso_oe_o == (rise_cnt_reg >= 5'h08)) else $error("answer enable out of place");
    a_unknown_refused: assert property (@(posedge sclk_i) disable iff (ss_b_i || !rst_b_i)
        (rise_cnt_reg == 5'h08 && !ins_known) |-> s_refusal_head) else $error("unknown byte not refused");
    a_tail_zero: assert property (@(posedge sclk_i) disable iff (ss_b_i || !rst_b_i)
        rise_cnt_reg >= 5'h18 |-> !miso_o) else $error("data after answer end");
    a_result_lsb_zero: assert property (@(posedge sclk_i) disable iff (ss_b_i || !rst_b_i)
        (rise_cnt_reg == 5'h17 && ins_reg == CMD_RESULT) |-> !miso_o) else $error("result bit 0 set");
    // ==========================================
    // main clock side
    a_deselect_off: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        ss_b_i |-> !miso_oe_o) else $error("driving while deselected");
    a_idle_zero: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        !miso_oe_o |-> !miso_o) else $error("data while not answering");
    a_reset_mode: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        $rose(rst_b_i) |-> !conv_power_o && !mux_select_o) else $error("mode not cleared");
    a_sleep_no_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        !conv_power_o [*2] |-> !sample_hold_o) else $error("hold while asleep");
    a_hold_span: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        $rose(sample_hold_o) |-> sample_hold_o [*8]) else $error("hold too short");
endmodule
bind rsa_cmd_port rsa_cmd_port_sva i_rsa_cmd_port_sva (.mclk_i(mclk_i),
    .rst_b_i(rst_b_i), .sclk_i(sclk_i), .ss_b_i(ss_b_i), .mosi_i(mosi_i),
    .miso_o(miso_o), .miso_oe_o(miso_oe_o), .sample_hold_o(sample_hold_o),
    .mux_select_o(mux_select_o), .conv_power_o(conv_power_o));

/* tb/rsa_host_model.sv */
// host serial master that runs instruction frames
`timescale 1ns/100ps
module rsa_host_model (
    output logic sclk_o,
    output logic ss_b_o,
    output logic mosi_o,
    input wire logic miso_i
);
    // clock stands low and select high between frames
    initial begin
        sclk_o = 1'b0;
        ss_b_o = 1'b1;
        mosi_o = 1'b0;
    end
    // one frame of nbits clocks; answer gathered msb first
    task automatic xfer(input logic [7:0] ins, input int nbits,
                        output logic [15:0] ans);
        ans = 16'h0000;
        ss_b_o = 1'b0;
        #30;
        for (int k = 0; k < nbits; k++) begin
            // instruction msb first, then a toggling filler
            mosi_o = (k < 8) ? ins[7 - k] : ~mosi_o;
            #3 sclk_o = 1'b1;
            if (k >= 8 && k < 24) ans[23 - k] = miso_i;
            #3 sclk_o = 1'b0;
        end
        // short nbits ends the frame early
        #10 ss_b_o = 1'b1;
        #60;
    endtask
endmodule

/* tb/rsa_cmd_port_bench.sv */
// self-checking bench for the converter command port
`timescale 1ns/100ps
module rsa_cmd_port_bench import rsa_pkg::*;;
    // ==========================================
    // stimulus rows
    typedef struct packed {
        logic [15:0] gap; // mclk cycles before the frame
        logic [7:0] ins;
        logic [4:0] nbits;
        logic [15:0] exp;
        logic [15:0] mask;
    } rsa_row_s;
    // levels in code units; millivolt scaling is the host's job
    localparam logic [10:0] RATE_LVL = 11'h3f0; // analog rate level
    localparam logic [10:0] TEMP_LVL = 11'h5a5; // analog temperature level
    logic mclk = 1'b0;
    logic rst_b;
    wire logic sclk, ss_b, mosi, miso, miso_oe, sample_hold, mux_select;
    wire logic conv_power, cmp_above, miso_w;
    wire logic [10:0] dac_code;
    int err_count = 0;
    int total_checks = 0;
    rsa_row_s rows [14];
    always #12.5 mclk = ~mclk;
    // released line has no pull, so it shows the inverse of miso, which is low while released, so it reads high
    // comparator models input half an lsb up
    assign miso_w = miso_oe ? miso : ~miso;
    assign cmp_above = dac_code <= (mux_select ? TEMP_LVL : RATE_LVL);
    rsa_cmd_port #(.INIT_CYCLES(40), .TRACK_CYCLES(2), .BIT_CYCLES(6))
    i_rsa_cmd_port (.mclk_i(mclk), .rst_b_i(rst_b), .sclk_i(sclk),
        .ss_b_i(ss_b), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
        .cmp_above_i(cmp_above), .dac_code_o(dac_code),
        .sample_hold_o(sample_hold), .mux_select_o(mux_select),
        .conv_power_o(conv_power));
    rsa_host_model i_rsa_host_model (.sclk_o(sclk), .ss_b_o(ss_b),
        .mosi_o(mosi), .miso_i(miso_w));
    // ==========================================
    // helpers
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    task automatic frame(input logic [7:0] ins, input int n,
                         output logic [15:0] ans);
        tick(1);
        i_rsa_host_model.xfer(ins, n, ans);
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input logic [15:0] mask);
        total_checks++;
        if ((seen & mask) !== (exp & mask)) begin
            err_count++;
            $display("BAD %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ==========================================
    // main sequence
    initial begin
        logic [15:0] ans;
        rows = '{
            '{16'h0, 8'h88, 5'h18, 16'h2000, 16'hffff},
            '{16'h0, 8'ha5, 5'h18, 16'he000, 16'hffff},
            '{16'h0, 8'h98, 5'h18, 16'h2008, 16'hffff},
            '{16'h0, 8'h88, 5'h19, 16'h2008, 16'hffff},
            '{16'h0, 8'h94, 5'h18, 16'h0004, 16'hffff},
            '{16'h0, 8'h94, 5'h18, 16'h8000, 16'hffff},
            '{16'h0, 8'h80, 5'h18, 16'h0000, 16'he001},
            '{16'hc8, 8'h80, 5'h18, 16'h2000, 16'he001},
            '{16'h0, 8'h9c, 5'h18, 16'h000c, 16'hffff},
            '{16'hc8, 8'h80, 5'h18, {4'h2, TEMP_LVL, 1'b0}, 16'hffff},
            '{16'h0, 8'h94, 5'h18, 16'h0004, 16'hffff},
            '{16'hc8, 8'h80, 5'h18, {4'h2, RATE_LVL, 1'b0}, 16'hffff},
            '{16'h0, 8'h9d, 5'h18, 16'he000, 16'hffff},
            '{16'h0, 8'h90, 5'h18, 16'h2000, 16'hffff}
        };
        rst_b = 1'b0;
        tick(10);
        rst_b = 1'b1;
        tick(100);
        foreach (rows[i]) begin
            tick(int'(rows[i].gap));
            frame(rows[i].ins, int'(rows[i].nbits), ans);
            check(ans, rows[i].exp, rows[i].mask);
            $display("row %0d done", i);
        end
        // a start drives the mux and power pins
        frame(8'h9c, 24, ans);
        tick(10);
        check({14'h0000, mux_select, conv_power}, 16'h0003, 16'hffff);
        $display("mode pins test done");
        // reset mid-conversion, then a frame while initialising
        rst_b = 1'b0;
        tick(10);
        check({13'h0000, mux_select, conv_power, miso_oe}, 16'h0, 16'hffff);
        rst_b = 1'b1;
        frame(8'h88, 24, ans);
        check(ans, 16'ha400, 16'hffff);
        tick(100);
        frame(8'h88, 24, ans);
        check(ans, 16'h2000, 16'hffff);
        $display("reset test done");
        // deselect inside the instruction byte, then a truncated answer
        frame(8'h9c, 5, ans);
        frame(8'h88, 24, ans);
        check(ans, 16'h2000, 16'hffff);
        check({15'h0000, conv_power}, 16'h0, 16'hffff);
        frame(8'h88, 16, ans);
        check(ans, 16'h2000, 16'hff00);
        check({15'h0000, miso_oe}, 16'h0, 16'hffff);
        $display("deselect test done");
        conclude();
    end
    // watchdog well past the expected run length
    initial begin
        repeat (8000) @(posedge mclk);
        err_count++;
        $display("BAD %0t: watchdog expired", $time);
        conclude();
    end
endmodule
